// [shared/salr_pkg.sv]
// Constants and carrier types for the status alarm pin router
//
// Operation
// - Latch-selected status bits except 23, 19, 18 and 3 hold at one until software force-clears them.
// - Status bits not latch-selected follow their condition, threshold bits through the interval snapshot.
// - Force-on sets, force-off clears the matching status bit only.
// - Force-on and force-off registers return to zero once applied.
// - Bits 23..18: results ready, extreme update, dips A/B, polarities A/B.
// - Bits 17..10: hot, cold, fast, slow, line A high/low, line B high/low.
// - Bits 9..4: spikes A/B, power one/two high, current one/two high.
// - Bit 3 crystal, bits 2..1 switches, bit 0 reset flag; 2..0 always latch.
// - Pin level reads input pins and drives output pins.
// - Direction bit one means input, zero means output.
// - An unconnected input pin reads as one through its pull-up.
// - Every pin is an input while reset is applied.
// - Select and address straps are sampled on the fifth clock after reset is released.
// - First select strap low picks SPI; otherwise other straps pick mode.
// - Output pins are active low by default.
// - A set invert bit makes that output pin active high.
// - Routed pin without a switch route bit is on when a status bit and its route bit are set.
// - Other routed status bits set automatically set the switch bit.
// - Switch pins change a programmed sample count after reference crossings.
// - Switch timers add one sample of pipeline latency.
// - Threshold alarms update once per accumulation interval.
`default_nettype none

package salr_pkg;

  localparam int SALR_DW = 24;
  localparam int SALR_AW = 8;
  localparam int SALR_BW = 32;
  localparam int SALR_PIN_N = 11;
  localparam int SALR_ROUTE_N = 5;
  localparam int SALR_DELAY_W = 16;

  // ---------------------------------------------------------------
  // Register offsets
  // ---------------------------------------------------------------
  localparam logic [7:0] OFS_STATUS = 8'h00;
  localparam logic [7:0] OFS_LATCH = 8'h04;
  localparam logic [7:0] OFS_FORCE_ON = 8'h08;
  localparam logic [7:0] OFS_FORCE_OFF = 8'h0c;
  localparam logic [7:0] OFS_LEVEL = 8'h10;
  localparam logic [7:0] OFS_DIR = 8'h14;
  localparam logic [7:0] OFS_INVERT = 8'h18;
  localparam logic [7:0] OFS_ROUTE0 = 8'h1c;
  localparam logic [7:0] OFS_DELAY0 = 8'h30;
  localparam logic [7:0] OFS_STRAP = 8'h40;

  // ---------------------------------------------------------------
  // Status bit layout
  // ---------------------------------------------------------------
  localparam int BIT_POL_A = 19;
  localparam int BIT_POL_B = 18;
  localparam int BIT_SW_ONE = 2;
  localparam int BIT_SW_TWO = 1;
  localparam logic [23:0] LATCHABLE = 24'h73fff0;
  localparam logic [23:0] ALWAYS_LATCH = 24'h000007;
  localparam logic [23:0] THRESH_BITS = 24'h03fcf0;
  localparam logic [23:0] SWITCH_BITS = 24'h000006;
  localparam logic [23:0] STATUS_RST = 24'h000001;

  // ---------------------------------------------------------------
  // Pins and reset values
  // ---------------------------------------------------------------
  localparam logic [23:0] PIN_MASK = 24'h0007ff;
  localparam logic [23:0] DIR_RST = 24'h0007ff;
  localparam logic [23:0] LEVEL_RST = 24'h0007ff;
  localparam int ROUTE_PIN [SALR_ROUTE_N] = '{0, 4, 6, 7, 10};
  localparam int PIN_SEL0 = 8;
  localparam int PIN_SEL1 = 9;
  localparam int PIN_ADR0 = 1;
  localparam int PIN_ADR1 = 6;
  localparam logic [2:0] STRAP_WAIT = 3'h4;

  // ---------------------------------------------------------------
  // Timing
  // ---------------------------------------------------------------
  localparam int CLK_PERIOD_NS = 100;
  localparam int SAMPLE_NS = 250000;
  localparam int SAMPLE_CYCLES = SAMPLE_NS / CLK_PERIOD_NS;
  localparam int DIV_W = 12;

  typedef enum logic [1:0] {SALR_HOST_SPI, SALR_HOST_UART, SALR_HOST_I2C} salr_host_type;
  typedef enum logic [1:0] {RLY_IDLE, RLY_WAIT, RLY_COUNT} salr_relay_state_type;

  typedef struct packed {
    logic wr;
    logic rd;
    logic [SALR_AW-1:0] addr;
    logic [SALR_BW-1:0] wdata;
  } salr_req_type;

  typedef struct packed {
    logic [SALR_PIN_N-1:0] out;
    logic [SALR_PIN_N-1:0] oe;
  } salr_pin_drive_type;

endpackage : salr_pkg

`default_nettype wire

// [src/salr_relay_timer.sv]
// Zero-crossing aligned delay timer for one switch output
`default_nettype none

module salr_relay_timer
  import salr_pkg::*;
#(
  parameter int DELAY_W = SALR_DELAY_W
) (
  input wire logic mclk,
  input wire logic reset,
  input wire logic sample_tick,
  input wire logic ref_level,
  input wire logic request,
  input wire logic [DELAY_W-1:0] on_delay,
  input wire logic [DELAY_W-1:0] off_delay,
  output logic drive
);

  typedef struct packed {
    salr_relay_state_type st;
    logic [DELAY_W-1:0] cnt;
    logic ref_prev;
    logic drive;
  } salr_timer_state_type;

  salr_timer_state_type r;
  salr_timer_state_type n;
  logic rise;
  logic fall;

  assign rise = sample_tick & ref_level & ~r.ref_prev;
  assign fall = sample_tick & ~ref_level & r.ref_prev;
  assign drive = r.drive;

  always_comb begin
    n = r;
    if (sample_tick) begin
      n.ref_prev = ref_level;
    end
    case (r.st)
      RLY_IDLE: begin
        if (request != r.drive) begin
          n.st = RLY_WAIT;
        end
      end
      RLY_WAIT: begin
        if (request == r.drive) begin
          n.st = RLY_IDLE;
        end else if (request ? rise : fall) begin
          n.cnt = request ? on_delay : off_delay;
          n.st = RLY_COUNT;
        end
      end
      RLY_COUNT: begin
        if (request == r.drive) begin
          n.st = RLY_IDLE;
        end else if (sample_tick) begin
          if (r.cnt == '0) begin
            n.drive = request;
            n.st = RLY_IDLE;
          end else begin
            n.cnt = r.cnt - 1'b1;
          end
        end
      end
      default: begin
        n.st = RLY_IDLE;
      end
    endcase
  end

  always_ff @(posedge mclk or posedge reset) begin
    if (reset) begin
      r <= '{st: RLY_IDLE, cnt: '0, ref_prev: 1'b0, drive: 1'b0};
    end else begin
      r <= n;
    end
  end

  AST_SW_ON_TICK: assert property (
    @(posedge mclk) disable iff (reset) !sample_tick |=> $stable(r.drive))
    else $error("switch drive changed between samples");

  AST_SW_DELAY_END: assert property (
    @(posedge mclk) disable iff (reset)
    (r.st == RLY_COUNT && sample_tick && r.cnt == '0 && request != r.drive)
    |=> r.drive == $past(request))
    else $error("switch drive missed end of delay");

endmodule : salr_relay_timer

`default_nettype wire

// [src/salr_router.sv]
// Status word, pin port, pin routing and switch timing
`default_nettype none

module salr_router
  import salr_pkg::*;
(
  input wire logic mclk,
  input wire logic reset,
  input wire salr_req_type req,
  output logic [SALR_BW-1:0] rdata,
  input wire logic [SALR_DW-1:0] cond,
  input wire logic interval_tick,
  input wire logic [SALR_PIN_N-1:0] pin_in,
  output salr_pin_drive_type pin_drv,
  output salr_host_type host_mode,
  output logic [1:0] host_addr,
  output logic strap_valid
);

  typedef struct packed {
    logic [SALR_DW-1:0] status;
    logic [SALR_DW-1:0] latch;
    logic [SALR_DW-1:0] fset;
    logic [SALR_DW-1:0] fclr;
    logic [SALR_DW-1:0] level;
    logic [SALR_DW-1:0] dir;
    logic [SALR_DW-1:0] invert;
    logic [SALR_ROUTE_N-1:0][SALR_DW-1:0] route;
    logic [3:0][SALR_DELAY_W-1:0] dly;
    logic [SALR_DW-1:0] thr;
    logic [SALR_PIN_N-1:0] s1;
    logic [SALR_PIN_N-1:0] s2;
    logic [SALR_PIN_N-1:0] s3;
    logic [SALR_PIN_N-1:0] pin_val;
    logic [SALR_PIN_N-1:0] pin_out;
    logic [SALR_PIN_N-1:0] pin_oe;
    logic [DIV_W-1:0] div;
    logic [2:0] strap_cnt;
    logic strap_done;
    salr_host_type host;
    logic [1:0] addr;
    logic [SALR_BW-1:0] rdata;
  } salr_state_type;

  salr_state_type r;
  salr_state_type n;

  logic sample_tick;
  logic [SALR_DW-1:0] lat_eff;
  logic [SALR_DW-1:0] cond_eff;
  logic [SALR_DW-1:0] fon;
  logic [SALR_DW-1:0] auto_set;
  logic [SALR_DW-1:0] level_rd;
  logic [SALR_DW-1:0] hold_v;
  logic [SALR_PIN_N-1:0] pin_on;
  logic [1:0] sw_drive;

  // ---------------------------------------------------------------
  // Status word
  // ---------------------------------------------------------------
  assign lat_eff = (r.latch & LATCHABLE) | ALWAYS_LATCH;
  assign fon = r.fset & ~r.fclr;
  assign hold_v = r.status & lat_eff & ~r.fclr;

  // Threshold alarms come from the interval snapshot, switch bits from routing
  assign cond_eff = (cond & ~THRESH_BITS & ~ALWAYS_LATCH) | r.thr | auto_set;

  // Level based: clear the routed alarm before its switch bit, or it sets again
  always_comb begin
    auto_set = '0;
    for (int m = 0; m < SALR_ROUTE_N; m++) begin
      if ((r.route[m] & SWITCH_BITS) != '0 &&
          (r.route[m] & r.status & ~SWITCH_BITS) != '0) begin
        auto_set = auto_set | (r.route[m] & SWITCH_BITS);
      end
    end
  end

  // ---------------------------------------------------------------
  // Pin routing
  // ---------------------------------------------------------------
  always_comb begin
    pin_on = ~r.level[SALR_PIN_N-1:0];
    for (int m = 0; m < SALR_ROUTE_N; m++) begin
      if (r.route[m][BIT_SW_ONE]) begin
        pin_on[ROUTE_PIN[m]] = sw_drive[0];
      end else if (r.route[m][BIT_SW_TWO]) begin
        pin_on[ROUTE_PIN[m]] = sw_drive[1];
      end else if (r.route[m] != '0) begin
        pin_on[ROUTE_PIN[m]] = |(r.status & r.route[m]);
      end
    end
  end

  // Input pins show the filtered pin, output pins the written level
  assign level_rd = ((PIN_MASK & {13'h0, r.pin_val} & r.dir) |
                     (r.level & ~r.dir)) & PIN_MASK;

  assign sample_tick = (r.div == DIV_W'(SAMPLE_CYCLES - 1));

  // ---------------------------------------------------------------
  // Switch timers
  // ---------------------------------------------------------------
  for (genvar g = 0; g < 2; g++) begin : g_sw
    salr_relay_timer #(
      .DELAY_W(SALR_DELAY_W)
    ) u_timer (
      .mclk(mclk),
      .reset(reset),
      .sample_tick(sample_tick),
      .ref_level(cond[g == 0 ? BIT_POL_A : BIT_POL_B]),
      .request(r.status[g == 0 ? BIT_SW_ONE : BIT_SW_TWO]),
      .on_delay(r.dly[2 * g]),
      .off_delay(r.dly[2 * g + 1]),
      .drive(sw_drive[g])
    );
  end

  // ---------------------------------------------------------------
  // Next state
  // ---------------------------------------------------------------
  always_comb begin
    n = r;
    n.s1 = pin_in;
    n.s2 = r.s1;
    n.s3 = r.s2;
    // A pin change counts once two stages agree
    n.pin_val = (r.s2 & r.s3) | (r.pin_val & (r.s2 | r.s3));
    n.div = sample_tick ? '0 : r.div + 1'b1;
    if (interval_tick) begin
      n.thr = cond & THRESH_BITS;
    end
    // Hardware sets after force clear so a fresh event is kept
    n.status = (((r.status | r.fset) & ~r.fclr) & lat_eff)
               | cond_eff
               | (fon & ~lat_eff);
    n.fset = '0;
    n.fclr = '0;
    n.pin_out = ~(pin_on ^ r.invert[SALR_PIN_N-1:0]);
    n.pin_oe = ~r.dir[SALR_PIN_N-1:0];
    n.rdata = '0;

    if (req.wr) begin
      case (req.addr)
        OFS_LATCH: begin
          n.latch = req.wdata[SALR_DW-1:0];
        end
        OFS_FORCE_ON: begin
          n.fset = req.wdata[SALR_DW-1:0];
        end
        OFS_FORCE_OFF: begin
          n.fclr = req.wdata[SALR_DW-1:0];
        end
        OFS_LEVEL: begin
          n.level = req.wdata[SALR_DW-1:0] & PIN_MASK;
        end
        OFS_DIR: begin
          n.dir = req.wdata[SALR_DW-1:0] & PIN_MASK;
        end
        OFS_INVERT: begin
          n.invert = req.wdata[SALR_DW-1:0] & PIN_MASK;
        end
        default: begin
          for (int m = 0; m < SALR_ROUTE_N; m++) begin
            if (req.addr == OFS_ROUTE0 + 8'(4 * m)) begin
              n.route[m] = req.wdata[SALR_DW-1:0];
            end
          end
          for (int i = 0; i < 4; i++) begin
            if (req.addr == OFS_DELAY0 + 8'(4 * i)) begin
              n.dly[i] = req.wdata[SALR_DELAY_W-1:0];
            end
          end
        end
      endcase
    end

    if (req.rd) begin
      case (req.addr)
        OFS_STATUS: begin
          n.rdata = {8'h00, r.status};
        end
        OFS_LATCH: begin
          n.rdata = {8'h00, r.latch};
        end
        OFS_FORCE_ON: begin
          n.rdata = {8'h00, r.fset};
        end
        OFS_FORCE_OFF: begin
          n.rdata = {8'h00, r.fclr};
        end
        OFS_LEVEL: begin
          n.rdata = {8'h00, level_rd};
        end
        OFS_DIR: begin
          n.rdata = {8'h00, r.dir};
        end
        OFS_INVERT: begin
          n.rdata = {8'h00, r.invert};
        end
        OFS_STRAP: begin
          n.rdata = {27'h0, r.strap_done, r.host, r.addr};
        end
        default: begin
          for (int m = 0; m < SALR_ROUTE_N; m++) begin
            if (req.addr == OFS_ROUTE0 + 8'(4 * m)) begin
              n.rdata = {8'h00, r.route[m]};
            end
          end
          for (int i = 0; i < 4; i++) begin
            if (req.addr == OFS_DELAY0 + 8'(4 * i)) begin
              n.rdata = {16'h0000, r.dly[i]};
            end
          end
        end
      endcase
    end

    // Straps are taken once the synchroniser has seen the released pins
    if (!r.strap_done) begin
      if (r.strap_cnt == STRAP_WAIT) begin
        n.strap_done = 1'b1;
        if (!r.pin_val[PIN_SEL0]) begin
          n.host = SALR_HOST_SPI;
          n.addr = 2'h0;
        end else begin
          n.host = r.pin_val[PIN_SEL1] ? SALR_HOST_I2C : SALR_HOST_UART;
          n.addr = {r.pin_val[PIN_ADR1], r.pin_val[PIN_ADR0]};
        end
      end else begin
        n.strap_cnt = r.strap_cnt + 1'b1;
      end
    end
  end

  always_ff @(posedge mclk or posedge reset) begin
    if (reset) begin
      r <= '0;
      r.status <= STATUS_RST;
      r.dir <= DIR_RST;
      r.level <= LEVEL_RST;
      r.s1 <= '1;
      r.s2 <= '1;
      r.s3 <= '1;
      r.pin_val <= '1;
      r.pin_out <= '1;
      r.host <= SALR_HOST_SPI;
    end else begin
      r <= n;
    end
  end

  assign rdata = r.rdata;
  assign pin_drv = '{out: r.pin_out, oe: r.pin_oe};
  assign host_mode = r.host;
  assign host_addr = r.addr;
  assign strap_valid = r.strap_done;

  // ---------------------------------------------------------------
  // Assertions
  // ---------------------------------------------------------------
  default clocking cb @(posedge mclk);
  endclocking
  default disable iff (reset);

  AST_STICKY_HOLD: assert property (
    1'b1 |=> ($past(hold_v) & ~r.status) == '0)
    else $error("latched status bit dropped without force clear");

  AST_FOLLOW: assert property (
    1'b1 |=> ((r.status ^ $past(cond_eff)) & ~$past(lat_eff) & ~$past(fon)) == '0)
    else $error("unlatched status bit does not follow condition");

  AST_FORCE_SET: assert property (
    r.fset != '0 |=> ($past(fon) & ~r.status) == '0)
    else $error("force on did not set status bit");

  AST_FORCE_SELFCLR: assert property (
    !req.wr |=> r.fset == '0 && r.fclr == '0)
    else $error("force register not returned to zero");

  AST_CLEAR_WINS: assert property (
    1'b1 |=> ($past(r.fset) & $past(r.fclr) & ~$past(cond_eff) & r.status) == '0)
    else $error("force off lost against force on");

  AST_DIR_OE: assert property (
    1'b1 |=> r.pin_oe == ~$past(r.dir[SALR_PIN_N-1:0]))
    else $error("pin enable does not match direction");

  AST_ROUTE_ACTIVE: assert property (
    (r.route[0][BIT_SW_ONE:BIT_SW_TWO] == 2'h0 && (r.status & r.route[0]) != '0)
    |=> r.pin_out[ROUTE_PIN[0]] == $past(r.invert[ROUTE_PIN[0]]))
    else $error("routed pin not active");

  AST_READBACK: assert property (
    (req.rd && req.addr == OFS_LEVEL) |=> rdata == {8'h00, $past(level_rd)})
    else $error("pin level read wrong");

  AST_SPI_MODE: assert property (
    ($rose(r.strap_done) && !$past(r.pin_val[PIN_SEL0])) |-> host_mode == SALR_HOST_SPI)
    else $error("strap low did not select spi");

  AST_SW_AUTO: assert property (
    auto_set != '0 |=> ($past(auto_set) & ~r.status) == '0)
    else $error("switch bit not set by routed alarm");

  AST_RESET_INPUTS: assert property (
    @(posedge mclk) disable iff (1'b0) reset |-> pin_drv.oe == '0)
    else $error("pin driven during reset");

  AST_FORCE_CLR: assert property (
    r.fclr != '0 |=> ($past(r.fclr) & ~$past(cond_eff) & r.status) == '0)
    else $error("force off did not clear status bit");

  AST_STRAP_ADDR: assert property (
    ($rose(r.strap_done) && $past(r.pin_val[PIN_SEL0])) |->
    host_addr == {$past(r.pin_val[PIN_ADR1]), $past(r.pin_val[PIN_ADR0])})
    else $error("strap address not captured");

  AST_THRESH_HOLD: assert property (
    !interval_tick |=> $stable(r.thr))
    else $error("threshold snapshot changed between intervals");

  AST_SW_ROUTE: assert property (
    r.route[0][BIT_SW_ONE] |=>
    r.pin_out[ROUTE_PIN[0]] == ~($past(sw_drive[0]) ^ $past(r.invert[ROUTE_PIN[0]])))
    else $error("switch routed pin not driven by its timer");

  AST_PLAIN_PIN: assert property (
    1'b1 |=> r.pin_out[PIN_ADR0] == ($past(r.level[PIN_ADR0]) ^ $past(r.invert[PIN_ADR0])))
    else $error("unrouted pin does not show level and invert");

  AST_PIN_SYNC: assert property (
    1'b1 |=> ((r.pin_val ^ $past(r.s2)) & ~($past(r.s2) ^ $past(r.s3))) == '0)
    else $error("pin value ignores agreeing sync stages");

  AST_RDATA_IDLE: assert property (
    !req.rd |=> rdata == '0)
    else $error("read data not zero outside read answer");

  COV_FORCE: cover property (r.fset != '0 ##1 r.status != '0);
  COV_AUTO: cover property (auto_set != '0 ##1 r.status[BIT_SW_ONE]);
  COV_STICKY: cover property (hold_v != '0 ##1 hold_v != '0);
  COV_I2C: cover property ($rose(r.strap_done) && host_mode == SALR_HOST_I2C);
  COV_SW_DRIVE: cover property ($rose(sw_drive[0]));

endmodule : salr_router

`default_nettype wire

// [verification/salr_pin_model.sv]
// Board side of the pin port: pull-ups, strap resistors and external drivers
`default_nettype none

module salr_pin_model
  import salr_pkg::*;
(
  input wire salr_pin_drive_type pin_drv,
  input wire logic [SALR_PIN_N-1:0] ext_val,
  input wire logic [SALR_PIN_N-1:0] ext_oe,
  output logic [SALR_PIN_N-1:0] pin_in
);
  timeunit 1ns;
  timeprecision 1ns;

  // ---------------------------------------------------------------
  // Wire resolution
  // ---------------------------------------------------------------
  // Device driver wins, then a board driver, else the pull-up
  always_comb begin
    for (int i = 0; i < SALR_PIN_N; i++) begin
      if (pin_drv.oe[i]) begin
        pin_in[i] = pin_drv.out[i];
      end else if (ext_oe[i]) begin
        pin_in[i] = ext_val[i];
      end else begin
        pin_in[i] = 1'b1;
      end
    end
  end
endmodule : salr_pin_model

`default_nettype wire

// [verification/test_status_alarm_pin_router.sv]
// Self-checking bench for the status alarm pin router
`default_nettype none

`define CHK(g, e) begin check_count++; if ((g) !== (e)) begin error_cnt++; \
  $display("ERROR t=%0t got=%h exp=%h", $time, (g), (e)); end end

module test_status_alarm_pin_router
  import salr_pkg::*;
();
  timeunit 1ns;
  timeprecision 1ns;

  logic mclk;
  logic reset;
  logic interval_tick;
  salr_req_type req;
  logic [SALR_BW-1:0] rdata;
  logic [SALR_DW-1:0] cond;
  logic [SALR_PIN_N-1:0] pin_in;
  logic [SALR_PIN_N-1:0] ext_val;
  logic [SALR_PIN_N-1:0] ext_oe;
  salr_pin_drive_type pin_drv;
  salr_host_type host_mode;
  logic [1:0] host_addr;
  logic strap_valid;
  int error_cnt = 0;
  int check_count = 0;
  logic [31:0] exp_q[$];
  logic [31:0] exp_v;
  logic rd_pend = 1'b0;
  logic [23:0] r;
  logic [10:0] lv;
  logic [10:0] inv;
  int n;

  salr_router u_dut (.mclk(mclk), .reset(reset), .req(req), .rdata(rdata), .cond(cond),
    .interval_tick(interval_tick), .pin_in(pin_in), .pin_drv(pin_drv),
    .host_mode(host_mode), .host_addr(host_addr), .strap_valid(strap_valid));

  salr_pin_model u_pins (.pin_drv(pin_drv), .ext_val(ext_val), .ext_oe(ext_oe),
    .pin_in(pin_in));

  initial begin
    mclk = 1'b0;
    forever #50 mclk = ~mclk;
  end

  // ---------------------------------------------------------------
  // Bus tasks and verdict
  // ---------------------------------------------------------------
  task automatic tk(input int c);
    repeat (c) @(posedge mclk);
  endtask : tk

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    req <= '{wr: 1'b1, rd: 1'b0, addr: a, wdata: d};
    @(posedge mclk);
    req <= '0;
    @(posedge mclk);
  endtask : wr

  task automatic rd(input logic [7:0] a, input logic [31:0] e);
    exp_q.push_back(e);
    req <= '{wr: 1'b0, rd: 1'b1, addr: a, wdata: 32'h0};
    @(posedge mclk);
    req <= '0;
    @(posedge mclk);
  endtask : rd

  task automatic tick(input logic [23:0] c);
    cond <= c;
    interval_tick <= 1'b1;
    @(posedge mclk);
    interval_tick <= 1'b0;
    tk(3);
  endtask : tick

  task automatic do_reset();
    reset <= 1'b1;
    tk(3);
    `CHK(pin_drv.oe, 11'h000)
    reset <= 1'b0;
    tk(6);
    `CHK(strap_valid, 1'b1)
  endtask : do_reset

  task automatic test_done();
    $display("Checks %0d, mismatches %0d", check_count, error_cnt);
    if (error_cnt == 0 && check_count > 0) begin
      $display("ALL TESTS PASSED");
    end else begin
      $display("TESTS FAILED");
    end
    $finish;
  endtask : test_done

  // Read data stand only in the cycle after the strobe
  always @(posedge mclk) begin
    if (rd_pend) begin
      exp_v = exp_q.pop_front();
      `CHK(rdata, exp_v)
    end
    rd_pend = req.rd;
  end

  initial begin
    tk(60000);
    error_cnt++;
    test_done();
  end

  // ---------------------------------------------------------------
  // Main sequence
  // ---------------------------------------------------------------
  initial begin
    void'($urandom(13569));
    reset = 1'b1;
    req = '0;
    cond = '0;
    interval_tick = 1'b0;
    ext_val = '0;
    ext_oe = 11'h020;
    do_reset();
    `CHK(host_mode, SALR_HOST_I2C)
    `CHK(host_addr, 2'h3)
    rd(OFS_STATUS, 32'h1);
    rd(OFS_DIR, 32'h7ff);
    rd(OFS_LEVEL, 32'h7df);
    rd(OFS_STRAP, 32'h1b);
    rd(8'hfc, 32'h0);
    wr(OFS_STATUS, 32'hffffff);
    rd(OFS_STATUS, 32'h1);
    wr(OFS_FORCE_ON, 32'h2);
    rd(OFS_STATUS, 32'h3);
    rd(OFS_FORCE_ON, 32'h0);
    wr(OFS_FORCE_OFF, 32'h1);
    rd(OFS_STATUS, 32'h2);
    rd(OFS_FORCE_OFF, 32'h0);
    wr(OFS_FORCE_OFF, 32'h2);
    wr(OFS_FORCE_ON, 32'h1);
    // Sticky table, then plain following
    wr(OFS_LATCH, 32'hffffff);
    repeat (4) begin
      r = 24'($urandom()) & 24'hfffff8;
      tick(r);
      tick('0);
      rd(OFS_STATUS, {8'h0, r & 24'h73fff0 | 24'h1});
      wr(OFS_FORCE_OFF, 32'hfffffe);
      rd(OFS_STATUS, 32'h1);
    end
    wr(OFS_LATCH, 32'h0);
    repeat (4) begin
      r = 24'($urandom()) & 24'hfffff8;
      tick(r);
      rd(OFS_STATUS, {8'h0, r | 24'h1});
      tick('0);
      rd(OFS_STATUS, 32'h1);
    end
    // Pin port with pins 4..0 as outputs
    wr(OFS_DIR, 32'h7e0);
    for (int k = 0; k < 2; k++) begin
      lv = 11'($urandom());
      inv = (k == 1) ? 11'($urandom()) : 11'h0;
      wr(OFS_LEVEL, {21'h0, lv});
      wr(OFS_INVERT, {21'h0, inv});
      tk(4);
      `CHK(pin_drv.oe, 11'h01f)
      `CHK(pin_drv.out[4:0], lv[4:0] ^ inv[4:0])
      rd(OFS_LEVEL, {21'h0, 6'h3e, lv[4:0]});
    end
    wr(OFS_INVERT, 32'h0);
    wr(OFS_LATCH, 32'hffffff);
    wr(OFS_ROUTE0, 32'h10);
    wr(OFS_FORCE_ON, 32'h10);
    tk(4);
    `CHK(pin_drv.out[0], 1'b0)
    wr(OFS_FORCE_OFF, 32'h10);
    tk(4);
    `CHK(pin_drv.out[0], 1'b1)
    // Switch one on pin 0 with spike A as its trigger
    wr(OFS_ROUTE0, 32'h204);
    wr(OFS_DELAY0, 32'h2);
    wr(8'h34, 32'h1);
    wr(OFS_FORCE_ON, 32'h200);
    tk(2);
    rd(OFS_STATUS, 32'h205);
    tk(7500);
    `CHK(pin_drv.out[0], 1'b1)
    cond[19] <= 1'b1;
    n = 0;
    while (pin_drv.out[0] !== 1'b0 && n < 12000) begin
      @(posedge mclk);
      n++;
    end
    `CHK(n >= 7500 && n <= 10010, 1'b1)
    wr(OFS_FORCE_OFF, 32'h200);
    wr(OFS_FORCE_OFF, 32'h4);
    tk(7500);
    `CHK(pin_drv.out[0], 1'b0)
    cond[19] <= 1'b0;
    n = 0;
    while (pin_drv.out[0] !== 1'b1 && n < 12000) begin
      @(posedge mclk);
      n++;
    end
    `CHK(n >= 5000 && n <= 7510, 1'b1)
    // Second reset with the first select strap pulled low
    ext_oe <= 11'h120;
    do_reset();
    `CHK(host_mode, SALR_HOST_SPI)
    rd(OFS_STRAP, 32'h10);
    rd(OFS_STATUS, 32'h1);
    tk(2);
    test_done();
  end
endmodule : test_status_alarm_pin_router

`default_nettype wire
